// [verilog/tafac_regs.v]
// Filter, settle, channel select and alert register bank.
//
// Function
// - mean_count 00/01/10/11 averages 2/4/8/16; 00 gives 1 with the rank filter off.
// - rank_filter_size 00 off, else 4/8/16.
// - Writing soft_clear resets the digital logic.
// - settle_delay is 128 us steps up to 2.048 ms.
// - Settle delay before touch channels and first conversion.
// - Thermal mask blocks temperature interrupts.
// - Spare/battery mask blocks its interrupts.
// - Style bit picks data-available or limit alert.
// - Style selection overrides per-channel masks.
// - Pin alert mask blocks the pin alert.
// - Spare/battery low and high limit flags.
// - Temperature low and high limit flags.
// - Position select bits include Y and X.
// - Pressure select bits include both pressure measurements.
// - Select bits include aux, battery, temperature.
// - Pin function enabled ignores aux and battery.
// - Both selected, pin off: battery only.
// - Two spare/battery thresholds, reset to zero.
// - Two temperature thresholds, reset to zero.
// - Pin enable bit makes spare pin general purpose.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "tafac_defines.vh"
module tafac_regs (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rstn_in,
  // Avalon-MM slave
  input  wire [5:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  output reg  [1:0]  avs_response_out,
  // Conversion engine results
  input  wire        sb_result_valid_in,
  input  wire        th_result_valid_in,
  input  wire [15:0] result_in,
  input  wire        result_set_done_in,
  input  wire        seq_start_in,
  input  wire        touch_conv_start_in,
  input  wire        pin_event_in,
  // Settings to the engine
  output reg  [4:0]  mean_count_out,
  output reg  [4:0]  rank_filter_size_out,
  output reg  [6:0]  chan_enable_out,
  output wire        gpio_mode_out,
  output reg         settle_busy_out,
  output reg         soft_clear_out,
  // Alert pin
  output reg         alert_n_out
);
// ****************************************************************
// Registers
// ****************************************************************
  reg  [15:0] filt_reg;
  reg  [15:0] chsel_reg;
  reg  [15:0] sb_hi_reg;
  reg  [15:0] sb_lo_reg;
  reg  [15:0] th_hi_reg;
  reg  [15:0] th_lo_reg;
  reg         ack_reg;
  reg         first_done_reg;
  reg  [16:0] step_cnt_reg;
  reg  [3:0]  steps_left_reg;
  reg         data_avail_reg;
  reg         pin_flag_reg;
  wire        soft_rst;
  wire        rst_any;
  wire [3:0]  idx;
  wire        wr_go;
  wire [15:0] wmask;
  wire        mapped;
  wire        sb_below;
  wire        sb_above;
  wire        th_below;
  wire        th_above;
  wire [3:0]  settle_steps;
  wire        flags_alert;
  reg  [15:0] rd_mux;
  reg  [15:0] chsel_next;
// ****************************************************************
// Address decode and write strobes
// ****************************************************************
  // The bus handshake keeps the pin reset only, so an access that is
  // in flight when software resets the bank still completes.
  // Register write of the reset bit clears every register but the bus
  // handshake, read data and soft_clear_out on the next edge, so
  // software sees the bank at defaults.
  assign soft_rst = filt_reg[`TAFAC_SOFT_BIT];
  assign rst_any  = !rstn_in || soft_rst;
  assign idx      = avs_address_in[5:2];
  assign mapped   = (idx >= `TAFAC_IDX_FILT) && (idx <= `TAFAC_IDX_STAT);
  // One wait state: every access completes on the second edge.
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
  assign wr_go = avs_write_in && ack_reg;
  assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign gpio_mode_out = filt_reg[`TAFAC_GPIO_EN_BIT];
  assign settle_steps = filt_reg[`TAFAC_SETTLE_HI:`TAFAC_SETTLE_LO];
// ****************************************************************
// Limit comparators
// ****************************************************************
  // Both channels share one result bus; the valid strobe tells which
  // pair of thresholds applies.
  tafac_limit_cmp u_sb_cmp (
    .value_in  (result_in),
    .high_in   (sb_hi_reg),
    .low_in    (sb_lo_reg),
    .below_out (sb_below),
    .above_out (sb_above)
  );
  tafac_limit_cmp u_th_cmp (
    .value_in  (result_in),
    .high_in   (th_hi_reg),
    .low_in    (th_lo_reg),
    .below_out (th_below),
    .above_out (th_above)
  );
// ****************************************************************
// Bus handshake
// ****************************************************************
  // The acknowledge toggles, so a held request sees exactly one wait
  // state and back-to-back requests each take two cycles.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
    end
  end
// ****************************************************************
// Read data mux
// ****************************************************************
  always @* begin
    rd_mux = 16'h0000;
    case (idx)
      `TAFAC_IDX_FILT:  rd_mux = filt_reg;
      `TAFAC_IDX_CHSEL: rd_mux = chsel_reg;
      `TAFAC_IDX_SB_HI: rd_mux = sb_hi_reg;
      `TAFAC_IDX_SB_LO: rd_mux = sb_lo_reg;
      `TAFAC_IDX_TH_HI: rd_mux = th_hi_reg;
      `TAFAC_IDX_TH_LO: rd_mux = th_lo_reg;
      `TAFAC_IDX_STAT:  rd_mux = {13'h0000, pin_flag_reg, data_avail_reg,
                                  settle_busy_out};
      default:          rd_mux = 16'h0000;
    endcase
  end
  // Read data is latched in the wait cycle, so it already stands at
  // the edge where the master takes it.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= 2'h0;
    end else if ((avs_read_in || avs_write_in) && !ack_reg) begin
      avs_readdata_out <= {16'h0000, rd_mux};
      avs_response_out <= mapped ? 2'h0 : 2'h2;
    end
  end
// ****************************************************************
// Configuration registers
// ****************************************************************
  always @(posedge clk_in) begin
    if (rst_any) begin
      filt_reg  <= `TAFAC_FILT_RESET;
      sb_hi_reg <= `TAFAC_LIMIT_RESET;
      sb_lo_reg <= `TAFAC_LIMIT_RESET;
      th_hi_reg <= `TAFAC_LIMIT_RESET;
      th_lo_reg <= `TAFAC_LIMIT_RESET;
    end else if (wr_go) begin
      case (idx)
        `TAFAC_IDX_FILT:
          filt_reg <= (filt_reg & ~wmask) | (avs_writedata_in[15:0] & wmask);
        `TAFAC_IDX_SB_HI:
          sb_hi_reg <= (sb_hi_reg & ~wmask) | (avs_writedata_in[15:0] & wmask);
        `TAFAC_IDX_SB_LO:
          sb_lo_reg <= (sb_lo_reg & ~wmask) | (avs_writedata_in[15:0] & wmask);
        `TAFAC_IDX_TH_HI:
          th_hi_reg <= (th_hi_reg & ~wmask) | (avs_writedata_in[15:0] & wmask);
        `TAFAC_IDX_TH_LO:
          th_lo_reg <= (th_lo_reg & ~wmask) | (avs_writedata_in[15:0] & wmask);
        default: begin
        end
      endcase
    end
  end
// ****************************************************************
// Soft reset pulse
// ****************************************************************
  // The pulse lets the engine drop its own state one cycle later.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      soft_clear_out <= 1'b0;
    end else begin
      soft_clear_out <= soft_rst;
    end
  end
// ****************************************************************
// Channel select, masks and limit flags
// ****************************************************************
  // Flags are sticky; a comparator hit in the same cycle as a
  // software write of zero keeps the flag set.
  always @* begin
    chsel_next = chsel_reg;
    if (wr_go && idx == `TAFAC_IDX_CHSEL) begin
      chsel_next = (chsel_reg & ~wmask) | (avs_writedata_in[15:0] & wmask);
    end
    chsel_next[0] = 1'b0;
    if (sb_result_valid_in) begin
      if (sb_below) chsel_next[`TAFAC_SB_LOW_BIT] = 1'b1;
      if (sb_above) chsel_next[`TAFAC_SB_HIGH_BIT] = 1'b1;
    end
    if (th_result_valid_in) begin
      if (th_below) chsel_next[`TAFAC_TH_LOW_BIT] = 1'b1;
      if (th_above) chsel_next[`TAFAC_TH_HIGH_BIT] = 1'b1;
    end
  end
  always @(posedge clk_in) begin
    if (rst_any) begin
      chsel_reg <= `TAFAC_CHSEL_RESET;
    end else begin
      chsel_reg <= chsel_next;
    end
  end
// ****************************************************************
// Channel enables
// ****************************************************************
  // The shared pin measures one channel at a time, so battery wins
  // over aux when both are selected.
  always @(posedge clk_in) begin
    if (rst_any) begin
      chan_enable_out <= 7'h00;
    end else begin
      chan_enable_out[6] <= chsel_reg[`TAFAC_YPOS_BIT];
      chan_enable_out[5] <= chsel_reg[`TAFAC_XPOS_BIT];
      chan_enable_out[4] <= chsel_reg[`TAFAC_PRESS_A_BIT];
      chan_enable_out[3] <= chsel_reg[`TAFAC_PRESS_B_BIT];
      chan_enable_out[2] <= chsel_reg[`TAFAC_AUX_BIT] && !gpio_mode_out
                            && !chsel_reg[`TAFAC_BATT_BIT];
      chan_enable_out[1] <= chsel_reg[`TAFAC_BATT_BIT]
                            && !gpio_mode_out;
      chan_enable_out[0] <= chsel_reg[`TAFAC_TEMP_BIT];
    end
  end
// ****************************************************************
// Filter sizes
// ****************************************************************
  // Sizes go out as plain counts, so the datapath needs no decode.
  always @(posedge clk_in) begin
    if (rst_any) begin
      mean_count_out       <= 5'h01;
      rank_filter_size_out <= 5'h00;
    end else begin
      case (filt_reg[`TAFAC_RANK_HI:`TAFAC_RANK_LO])
        2'h1:    rank_filter_size_out <= 5'h04;
        2'h2:    rank_filter_size_out <= 5'h08;
        2'h3:    rank_filter_size_out <= 5'h10;
        default: rank_filter_size_out <= 5'h00;
      endcase
      case (filt_reg[`TAFAC_MEAN_HI:`TAFAC_MEAN_LO])
        2'h1:    mean_count_out <= 5'h04;
        2'h2:    mean_count_out <= 5'h08;
        2'h3:    mean_count_out <= 5'h10;
        default: mean_count_out <=
                   (filt_reg[`TAFAC_RANK_HI:`TAFAC_RANK_LO] == 2'h0) ?
                   5'h01 : 5'h02;
      endcase
    end
  end
// ****************************************************************
// Settle delay
// ****************************************************************
  // Code n gives (n+1) steps of 128 us; counted by a step divider.
  // The step length is fixed in core cycles; a faster clock needs a
  // new step count, not a new code.
  always @(posedge clk_in) begin
    if (rst_any) begin
      settle_busy_out <= 1'b0;
      step_cnt_reg    <= 17'h00000;
      steps_left_reg  <= 4'h0;
      first_done_reg  <= 1'b0;
    end else if (!settle_busy_out) begin
      if ((seq_start_in && !first_done_reg) || touch_conv_start_in) begin
        settle_busy_out <= 1'b1;
        steps_left_reg  <= settle_steps;
        step_cnt_reg    <= 17'h00000;
        first_done_reg  <= 1'b1;
      end
    end else if (step_cnt_reg == `TAFAC_STEP_LAST) begin
      step_cnt_reg <= 17'h00000;
      if (steps_left_reg == 4'h0) begin
        settle_busy_out <= 1'b0;
      end else begin
        steps_left_reg <= steps_left_reg - 4'h1;
      end
    end else begin
      step_cnt_reg <= step_cnt_reg + 17'h00001;
    end
  end
// ****************************************************************
// Alert output
// ****************************************************************
  assign flags_alert =
    (!chsel_reg[`TAFAC_SB_MASK_BIT] && (chsel_reg[`TAFAC_SB_LOW_BIT] ||
      chsel_reg[`TAFAC_SB_HIGH_BIT])) ||
    (!chsel_reg[`TAFAC_TH_MASK_BIT] && (chsel_reg[`TAFAC_TH_LOW_BIT] ||
      chsel_reg[`TAFAC_TH_HIGH_BIT])) ||
    (!chsel_reg[`TAFAC_PIN_MASK_BIT] && pin_flag_reg);
// ****************************************************************
// Status flags
// ****************************************************************
  // Data-available stays asserted until the status register is read.
  // A status read and a new event in one cycle leave the flag set.
  always @(posedge clk_in) begin
    if (rst_any) begin
      data_avail_reg <= 1'b0;
      pin_flag_reg   <= 1'b0;
    end else begin
      if (result_set_done_in) begin
        data_avail_reg <= 1'b1;
      end else if (avs_read_in && ack_reg && idx == `TAFAC_IDX_STAT) begin
        data_avail_reg <= 1'b0;
      end
      if (pin_event_in && gpio_mode_out) begin
        pin_flag_reg <= 1'b1;
      end else if (avs_read_in && ack_reg && idx == `TAFAC_IDX_STAT) begin
        pin_flag_reg <= 1'b0;
      end
    end
  end
  // The pin is registered so a glitch in the flag logic never shows.
  always @(posedge clk_in) begin
    if (rst_any) begin
      alert_n_out <= 1'b1;
    end else if (chsel_reg[`TAFAC_STYLE_BIT]) begin
      alert_n_out <= !flags_alert;
    end else begin
      alert_n_out <= !data_avail_reg;
    end
  end
endmodule // tafac_regs

// [verilog/tafac_defines.vh]
// Register map, field positions, reset values and timing counts.
`ifndef TAFAC_DEFINES_VH
`define TAFAC_DEFINES_VH
// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TAFAC_IDX_FILT      4'h2
`define TAFAC_IDX_CHSEL     4'h3
`define TAFAC_IDX_SB_HI     4'h4
`define TAFAC_IDX_SB_LO     4'h5
`define TAFAC_IDX_TH_HI     4'h6
`define TAFAC_IDX_TH_LO     4'h7
`define TAFAC_IDX_STAT      4'h8
// ****************************************************************
// Filter and delay configuration fields
// ****************************************************************
`define TAFAC_GPIO_EN_BIT   13
`define TAFAC_MEAN_HI       8
`define TAFAC_MEAN_LO       7
`define TAFAC_RANK_HI       6
`define TAFAC_RANK_LO       5
`define TAFAC_SOFT_BIT      4
`define TAFAC_SETTLE_HI     3
`define TAFAC_SETTLE_LO     0
`define TAFAC_FILT_RESET    16'h0000
// ****************************************************************
// Channel select and alert fields
// ****************************************************************
`define TAFAC_TH_MASK_BIT   15
`define TAFAC_SB_MASK_BIT   14
`define TAFAC_STYLE_BIT     13
`define TAFAC_PIN_MASK_BIT  12
`define TAFAC_SB_LOW_BIT    11
`define TAFAC_SB_HIGH_BIT   10
`define TAFAC_TH_LOW_BIT    9
`define TAFAC_TH_HIGH_BIT   8
`define TAFAC_YPOS_BIT      7
`define TAFAC_XPOS_BIT      6
`define TAFAC_PRESS_A_BIT   5
`define TAFAC_PRESS_B_BIT   4
`define TAFAC_AUX_BIT       3
`define TAFAC_BATT_BIT      2
`define TAFAC_TEMP_BIT      1
`define TAFAC_CHSEL_RESET   16'h0000
`define TAFAC_LIMIT_RESET   16'h0000
// ****************************************************************
// Timing
// ****************************************************************
`define TAFAC_CLK_MHZ       100
`define TAFAC_SETTLE_STEP_US 128
`define TAFAC_STEP_CYCLES   (`TAFAC_SETTLE_STEP_US * `TAFAC_CLK_MHZ)
// Last count of one settle step, sized for the step counter.
`define TAFAC_STEP_LAST     17'h031FF
`endif

// [verilog/tafac_limit_cmp.v]
// Threshold comparison of one measured channel.
`timescale 1ns/1ps
module tafac_limit_cmp (
  // Measured value and thresholds
  input  wire [15:0] value_in,
  input  wire [15:0] high_in,
  input  wire [15:0] low_in,
  // Comparison result
  output wire        below_out,
  output wire        above_out
);
  assign below_out = (value_in < low_in);
  assign above_out = (value_in > high_in);
endmodule // tafac_limit_cmp

// [testbench/tafac_regs_props.sv]
// Concurrent checks on the ports of the tafac register bank.
`timescale 1ns/1ps
`include "tafac_defines.vh"
module tafac_regs_props (
  // Clock and reset
  input wire        clk_in,
  input wire        rstn_in,
  // Bus
  input wire [5:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0]  avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire [1:0]  avs_response_out,
  // Engine side
  input wire        sb_result_valid_in,
  input wire        th_result_valid_in,
  input wire        result_set_done_in,
  input wire        seq_start_in,
  input wire        touch_conv_start_in,
  input wire        pin_event_in,
  input wire [4:0]  mean_count_out,
  input wire [4:0]  rank_filter_size_out,
  input wire [6:0]  chan_enable_out,
  input wire        gpio_mode_out,
  input wire        settle_busy_out,
  input wire        soft_clear_out,
  input wire        alert_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire [3:0]  idx  = avs_address_in[5:2];
  wire        took = !avs_waitrequest_out && (avs_read_in || avs_write_in);
  wire        unm  = idx < `TAFAC_IDX_FILT || idx > `TAFAC_IDX_STAT;
  wire        wr2  = took && avs_write_in && idx == `TAFAC_IDX_FILT &&
                     avs_byteenable_in[1:0] == 2'h3;
  wire        evs  = sb_result_valid_in || th_result_valid_in ||
                     result_set_done_in || pin_event_in;
  wire        why  = evs || (took && avs_write_in);
  reg  [3:0]  set_code;
  reg  [17:0] busy_cnt;
  // The settle length is judged from the last code written, so a code
  // change while busy is not covered here.
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      set_code <= 4'h0;
      busy_cnt <= 18'h00000;
    end else begin
      if (wr2)
        set_code <= avs_writedata_in[4] ? 4'h0 : avs_writedata_in[3:0];
      busy_cnt <= settle_busy_out ? busy_cnt + 18'h00001 : 18'h00000;
    end
  end
  function [4:0] mean_of(input [3:0] c);
    mean_of = (c[3:2] == 2'h0) ? ((c[1:0] == 2'h0) ? 5'h01 : 5'h02)
                               : (5'h02 << c[3:2]);
  endfunction
  function [4:0] rank_of(input [1:0] c);
    rank_of = (c == 2'h0) ? 5'h00 : (5'h02 << c);
  endfunction
  sequence s_wait_cycle;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  sequence s_soft_pulse;
    soft_clear_out ##1 !soft_clear_out;
  endsequence
  property p_mean;
    wr2 && !avs_writedata_in[4] |-> ##2
      (mean_count_out == mean_of($past(avs_writedata_in[8:5], 2)));
  endproperty
  property p_rank;
    wr2 && !avs_writedata_in[4] |-> ##2
      (rank_filter_size_out == rank_of($past(avs_writedata_in[6:5], 2)));
  endproperty
  AST_WAIT_ONE: assert property ($rose(avs_read_in || avs_write_in)
    |-> s_wait_cycle) else $error("wait state count wrong");
  AST_UNMAPPED: assert property (took && avs_read_in && unm |->
    avs_response_out == 2'h2 && avs_readdata_out == 32'h00000000)
    else $error("unmapped read answer wrong");
  AST_UPPER_ZERO: assert property (took && avs_read_in && !unm |->
    avs_response_out == 2'h0 && avs_readdata_out[31:16] == 16'h0000)
    else $error("mapped read answer wrong");
  AST_MEAN_MAP: assert property (p_mean)
    else $error("mean count wrong");
  AST_RANK_MAP: assert property (p_rank) else $error("rank size wrong");
  AST_GPIO_MODE: assert property (wr2 && !avs_writedata_in[4] |=>
    gpio_mode_out == $past(avs_writedata_in[13]))
    else $error("pin mode wrong");
  AST_SOFT_PULSE: assert property (wr2 && avs_writedata_in[4]
    |-> ##[1:2] s_soft_pulse) else $error("soft clear pulse wrong");
  AST_SETTLE_LEN: assert property ($fell(settle_busy_out) |->
    busy_cnt == ({14'h0000, set_code} + 18'h00001) * 18'h03200)
    else $error("settle length wrong");
  AST_BUSY_CAUSE: assert property ($rose(settle_busy_out) |->
    $past(seq_start_in || touch_conv_start_in))
    else $error("settle without start");
  AST_GPIO_CHAN: assert property (gpio_mode_out [*3] |->
    chan_enable_out[2:1] == 2'h0) else $error("aux or batt kept");
  AST_AUX_BATT: assert property (!(chan_enable_out[2] &&
    chan_enable_out[1])) else $error("aux and batt together");
  AST_ALERT_CAUSE: assert property ($fell(alert_n_out) |->
    $past(why) || $past(why, 2) || $past(why, 3))
    else $error("alert without cause");
endmodule // tafac_regs_props
bind tafac_regs tafac_regs_props i_tafac_regs_props (
  .clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .avs_response_out(avs_response_out),
  .sb_result_valid_in(sb_result_valid_in),
  .th_result_valid_in(th_result_valid_in),
  .result_set_done_in(result_set_done_in), .seq_start_in(seq_start_in),
  .touch_conv_start_in(touch_conv_start_in), .pin_event_in(pin_event_in),
  .mean_count_out(mean_count_out),
  .rank_filter_size_out(rank_filter_size_out),
  .chan_enable_out(chan_enable_out), .gpio_mode_out(gpio_mode_out),
  .settle_busy_out(settle_busy_out), .soft_clear_out(soft_clear_out),
  .alert_n_out(alert_n_out));

// [testbench/tafac_regs_tb.sv]
// Self-checking bench for the tafac register bank.
`timescale 1ns/1ps
`define CHK(a, b) begin \
  compares = compares + 1; \
  if ((a) !== (b)) begin \
    fail_count = fail_count + 1; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); \
  end \
end
module tafac_regs_tb;
  reg         clk_in           = 1'b0;
  reg         rstn_in          = 1'b0;
  reg  [5:0]  avs_address_in   = 6'h00;
  reg         avs_read_in      = 1'b0;
  reg         avs_write_in     = 1'b0;
  reg  [31:0] avs_writedata_in = 32'h00000000;
  reg  [3:0]  avs_byteenable_in = 4'h3;
  reg  [5:0]  evt              = 6'h00;
  reg  [15:0] res              = 16'h0000;
  wire [31:0] avs_readdata_out;
  wire        avs_waitrequest_out;
  wire [1:0]  avs_response_out;
  wire [4:0]  mean_count_out;
  wire [4:0]  rank_filter_size_out;
  wire [6:0]  chan_enable_out;
  wire        gpio_mode_out;
  wire        settle_busy_out;
  wire        soft_clear_out;
  wire        alert_n_out;
  integer     fail_count = 0;
  integer     compares   = 0;
  integer     i;
  integer     cnt;
  reg  [15:0] q;
  reg  [1:0]  r;
  reg  [26:0] rows [0:5];
  always #5 clk_in = ~clk_in;
  tafac_regs i_tafac_regs (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .sb_result_valid_in(evt[0]),
    .th_result_valid_in(evt[1]), .result_in(res),
    .result_set_done_in(evt[2]), .seq_start_in(evt[3]),
    .touch_conv_start_in(evt[4]), .pin_event_in(evt[5]),
    .mean_count_out(mean_count_out),
    .rank_filter_size_out(rank_filter_size_out),
    .chan_enable_out(chan_enable_out), .gpio_mode_out(gpio_mode_out),
    .settle_busy_out(settle_busy_out), .soft_clear_out(soft_clear_out),
    .alert_n_out(alert_n_out));
  task test_done;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task bus(input w, input [3:0] idx, input [15:0] d);
    integer n;
    begin
      n = 0;
      avs_address_in <= {idx, 2'h0};
      avs_writedata_in <= {16'h0000, d};
      avs_write_in <= w;
      avs_read_in <= ~w;
      @(posedge clk_in);
      while (avs_waitrequest_out !== 1'b0) begin
        n = n + 1;
        if (n > 20) begin
          fail_count = fail_count + 1;
          test_done;
        end
        @(posedge clk_in);
      end
      q = avs_readdata_out[15:0];
      r = avs_response_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task ev(input integer k, input [15:0] v);
    begin
      res <= v;
      evt <= 6'h01 << k;
      @(posedge clk_in);
      evt <= 6'h00;
      repeat (3) @(posedge clk_in);
    end
  endtask
  // Two busy cycles have already gone by inside the event task.
  task settle(input integer k, input [31:0] want);
    begin
      ev(k, 16'h0000);
      cnt = 2;
      while (settle_busy_out === 1'b1 && cnt < 70000) begin
        cnt = cnt + 1;
        @(posedge clk_in);
      end
      `CHK(cnt, want)
    end
  endtask
  initial begin
    rows[0] = {16'h0000, 5'h01, 5'h00, 1'b0};
    rows[1] = {16'h0020, 5'h02, 5'h04, 1'b0};
    rows[2] = {16'h00C0, 5'h04, 5'h08, 1'b0};
    rows[3] = {16'h0160, 5'h08, 5'h10, 1'b0};
    rows[4] = {16'h0180, 5'h10, 5'h00, 1'b0};
    rows[5] = {16'h2183, 5'h10, 5'h00, 1'b1};
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    `CHK(alert_n_out, 1'b1)
    `CHK(mean_count_out, 5'h01)
    `CHK({rank_filter_size_out, chan_enable_out}, 12'h000)
    for (i = 2; i < 8; i = i + 1) begin
      bus(1'b0, i[3:0], 16'h0000);
      `CHK(q, 16'h0000)
    end
    bus(1'b1, 4'hF, 16'hFFFF);
    bus(1'b0, 4'hF, 16'h0000);
    `CHK({r, q}, 18'h20000)
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'b1, 4'h2, rows[i][26:11]);
      repeat (3) @(posedge clk_in);
      `CHK(mean_count_out, rows[i][10:6])
      `CHK(rank_filter_size_out, rows[i][5:1])
      `CHK(gpio_mode_out, rows[i][0])
      bus(1'b0, 4'h2, 16'h0000);
      `CHK(q, rows[i][26:11])
    end
    bus(1'b1, 4'h3, 16'h00FE);
    repeat (3) @(posedge clk_in);
    `CHK(chan_enable_out, 7'h79)
    bus(1'b1, 4'h2, 16'h0000);
    repeat (3) @(posedge clk_in);
    `CHK(chan_enable_out, 7'h7B)
    for (i = 4; i < 8; i = i + 1) begin
      bus(1'b1, i[3:0], i[0] ? 16'h0100 : 16'h0800);
      bus(1'b0, i[3:0], 16'h0000);
      `CHK(q, i[0] ? 16'h0100 : 16'h0800)
    end
    avs_byteenable_in <= 4'h1;
    bus(1'b1, 4'h4, 16'hFFFF);
    avs_byteenable_in <= 4'h3;
    bus(1'b0, 4'h4, 16'h0000);
    `CHK(q, 16'h08FF)
    bus(1'b1, 4'h3, 16'h2000);
    ev(0, 16'h0900);
    `CHK(alert_n_out, 1'b0)
    bus(1'b1, 4'h3, 16'h6000);
    ev(0, 16'h0900);
    ev(0, 16'h0050);
    `CHK(alert_n_out, 1'b1)
    bus(1'b0, 4'h3, 16'h0000);
    `CHK(q[11:8], 4'hC)
    bus(1'b1, 4'h3, 16'hA000);
    ev(1, 16'h0900);
    ev(1, 16'h0050);
    `CHK(alert_n_out, 1'b1)
    bus(1'b0, 4'h3, 16'h0000);
    `CHK(q[11:8], 4'h3)
    bus(1'b1, 4'h2, 16'h2000);
    bus(1'b1, 4'h3, 16'h3000);
    ev(5, 16'h0000);
    `CHK(alert_n_out, 1'b1)
    bus(1'b1, 4'h3, 16'h2000);
    ev(5, 16'h0000);
    `CHK(alert_n_out, 1'b0)
    bus(1'b1, 4'h3, 16'hC000);
    repeat (3) @(posedge clk_in);
    `CHK(alert_n_out, 1'b1)
    ev(2, 16'h0000);
    `CHK(alert_n_out, 1'b0)
    bus(1'b0, 4'h8, 16'h0000);
    `CHK(q[1], 1'b1)
    bus(1'b1, 4'h2, 16'h0010);
    repeat (3) @(posedge clk_in);
    bus(1'b0, 4'h4, 16'h0000);
    `CHK(q, 16'h0000)
    bus(1'b0, 4'h3, 16'h0000);
    `CHK(q, 16'h0000)
    settle(3, 32'h00003200);
    bus(1'b1, 4'h2, 16'h0001);
    settle(4, 32'h00006400);
    test_done;
  end
endmodule // tafac_regs_tb
